/* File: rtl/dcd_pkg.sv */
package dcd_pkg;

  localparam int DCD_BANK_W      = 3;
  localparam int DCD_ADDR_W      = 16;
  localparam int DCD_MR_NUM      = 4;
  localparam int DCD_MR_SEL_W    = 2;
  localparam int ADDR_TEN_BIT    = 10;
  localparam int ADDR_TWELVE_BIT = 12;

  // burst length field of mode_reg_zero
  localparam int         MR0_BL_LSB    = 0;
  localparam logic [1:0] MR0_BL_FIXED8 = 2'h0;
  localparam logic [1:0] MR0_BL_OTF    = 2'h1;
  localparam logic [1:0] MR0_BL_FIXED4 = 2'h2;

  // burst duration in clocks (two beats per clock)
  localparam logic [2:0] BURST_CYC_EIGHT = 3'h4;
  localparam logic [2:0] BURST_CYC_FOUR  = 3'h2;

  // clk_en_min_hold
  localparam int         CLK_PERIOD_PS   = 4000;
  localparam int         CKE_MIN_HOLD_PS = 15000;
  localparam int         CKE_HOLD_INT    =
    (CKE_MIN_HOLD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [3:0] CKE_HOLD_CYC    = 4'(CKE_HOLD_INT);

  // controller register indices (avalon word address)
  localparam logic [1:0] REG_CMD    = 2'h0;
  localparam logic [1:0] REG_ADDR   = 2'h1;
  localparam logic [1:0] REG_STATUS = 2'h2;
  localparam logic [1:0] REG_CTRL   = 2'h3;

  localparam int CMD_CODE_LSB  = 0;
  localparam int CMD_CKE_BIT   = 4;
  localparam int ADDR_LSB      = 0;
  localparam int BANK_LSB      = 16;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_ERR_BIT  = 1;
  localparam int STAT_CKE_BIT  = 2;
  localparam int CTRL_RST_BIT  = 0;
  localparam int CTRL_TERM_BIT = 1;

  localparam logic [1:0]  CTRL_RESET_VAL = 2'h0;
  localparam logic [31:0] CMD_RESET_VAL  = 32'h0000_000f;

  // code = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}
  typedef enum logic [3:0] {
    CMD_MODE_WRITE = 4'b0000,
    CMD_ROW_RENEW  = 4'b0001,
    CMD_BANK_CLOSE = 4'b0010,
    CMD_ROW_OPEN   = 4'b0011,
    CMD_STORE      = 4'b0100,
    CMD_READ       = 4'b0101,
    CMD_IMP_CAL    = 4'b0110,
    CMD_IDLE_CYCLE = 4'b0111,
    CMD_CHIP_IDLE  = 4'b1111
  } dcd_cmd_t;

  typedef enum logic [1:0] {
    PWR_ON     = 2'b00,
    PWR_PD_PRE = 2'b01,
    PWR_PD_ACT = 2'b10
  } dcd_pwr_t;

  function automatic dcd_cmd_t dcd_decode(input logic [3:0] pins);
    if (pins[3]) begin
      return CMD_CHIP_IDLE;
    end
    return dcd_cmd_t'(pins);
  endfunction : dcd_decode

  function automatic logic dcd_is_idle(input dcd_cmd_t c);
    return (c == CMD_IDLE_CYCLE) || (c == CMD_CHIP_IDLE);
  endfunction : dcd_is_idle

endpackage : dcd_pkg

/* File: rtl/dcd_link_if.sv */
`timescale 1ns/1ps
interface dcd_link_if;
  import dcd_pkg::*;
  logic                  async_rst_n;
  logic                  clk_en;
  logic                  chip_sel_n;
  logic                  row_strobe_n;
  logic                  col_strobe_n;
  logic                  write_strobe_n;
  logic [DCD_BANK_W-1:0] array_sel;
  logic [DCD_ADDR_W-1:0] addr;
  logic                  term_en;

  modport dev (
    input async_rst_n, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
          write_strobe_n, array_sel, addr, term_en
  );
  modport ctl (
    output async_rst_n, clk_en, chip_sel_n, row_strobe_n, col_strobe_n,
           write_strobe_n, array_sel, addr, term_en
  );
endinterface : dcd_link_if

/* File: rtl/dcd_device.sv */
// The Avalon-MM slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
module dcd_device
  import dcd_pkg::*;
#(
  parameter int BANK_W = DCD_BANK_W,
  parameter int ADDR_W = DCD_ADDR_W
) (
  input  wire logic                                MCLK_I,
  input  wire logic                                RST_N_I,
  dcd_link_if.dev                                  lnk,
  output logic      [3:0]                          CMD_O,
  output logic                                     CMD_STB_O,
  output logic      [BANK_W-1:0]                   BANK_O,
  output logic      [ADDR_W-1:0]                   ADDR_O,
  output logic      [1:0]                          PWR_STATE_O,
  output logic                                     SELF_REF_O,
  output logic      [(1<<BANK_W)-1:0]              OPEN_BANKS_O,
  output logic                                     BURST_ACT_O,
  output logic                                     CHOP_O,
  output logic                                     AUTO_CLOSE_O,
  output logic                                     ZQ_LONG_O,
  output logic                                     ZQ_INIT_O,
  output logic      [DCD_MR_NUM-1:0][ADDR_W-1:0]   MODE_REGS_O,
  output logic                                     VIOLATION_O
);

  localparam int NBANK = 1 << BANK_W;

  logic                 rst_n;
  logic                 cke_prev_reg;
  dcd_pwr_t             pwr_reg;
  dcd_pwr_t             pwr_next;
  logic                 sref_reg;
  logic [NBANK-1:0]     open_reg;
  logic [NBANK-1:0]     open_next;
  logic [2:0]           burst_cnt_reg;
  logic [BANK_W-1:0]    burst_bank_reg;
  logic                 auto_close_reg;
  logic                 chop_reg;
  logic                 zq_seen_reg;
  dcd_cmd_t             cmd;
  logic                 exec;
  logic                 viol;
  logic                 self_refresh_entry;
  logic                 idle_ok;
  logic                 bank_open;
  logic                 chop;
  logic [1:0]           bl_field;
  logic                 burst_go;

  // either the local reset or the pin resets everything, no clock needed
  assign rst_n = RST_N_I & lnk.async_rst_n;

  // term_en is deliberately not read anywhere in the decoder

  always_comb begin
    cmd       = dcd_decode({lnk.chip_sel_n, lnk.row_strobe_n,
                            lnk.col_strobe_n, lnk.write_strobe_n});
    idle_ok   = (open_reg == '0) && (burst_cnt_reg == 3'h0) && cke_prev_reg;
    bank_open = open_reg[lnk.array_sel];
    bl_field  = MODE_REGS_O[0][MR0_BL_LSB +: 2];
    chop      = (bl_field == MR0_BL_OTF) ? !lnk.addr[ADDR_TWELVE_BIT]
                                         : (bl_field == MR0_BL_FIXED4);
    exec      = 1'b0;
    viol      = 1'b0;
    self_refresh_entry       = 1'b0;
    pwr_next  = pwr_reg;
    // all decisions look at the state held before this edge
    if (pwr_reg != PWR_ON) begin
      if (lnk.clk_en) begin
        pwr_next = PWR_ON;
        viol     = !dcd_is_idle(cmd);
      end
    end else if (cke_prev_reg && !lnk.clk_en) begin
      if (dcd_is_idle(cmd)) begin
        pwr_next = (open_reg != '0) ? PWR_PD_ACT : PWR_PD_PRE;
      end else if (cmd == CMD_ROW_RENEW && idle_ok) begin
        self_refresh_entry = 1'b1;
      end else begin
        viol = 1'b1;
      end
    end else if (!cke_prev_reg) begin
      // covers self refresh exit and the low clk_en after reset
      viol = lnk.clk_en && !dcd_is_idle(cmd);
    end else begin
      case (cmd)
        CMD_IDLE_CYCLE, CMD_CHIP_IDLE: exec = 1'b0;
        CMD_MODE_WRITE, CMD_ROW_RENEW: begin
          exec = idle_ok;
          viol = !idle_ok;
        end
        CMD_ROW_OPEN: begin
          exec = !bank_open;
          viol = bank_open;
        end
        CMD_READ, CMD_STORE: begin
          // a running burst cannot be cut short by a new one
          exec = bank_open && (burst_cnt_reg == 3'h0);
          viol = !exec;
        end
        CMD_BANK_CLOSE, CMD_IMP_CAL: exec = 1'b1;
        default: viol = 1'b1;
      endcase
    end
    burst_go  = exec && (cmd == CMD_READ || cmd == CMD_STORE);
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      cke_prev_reg <= 1'b0;
    end else begin
      cke_prev_reg <= lnk.clk_en;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      pwr_reg <= PWR_ON;
    end else begin
      pwr_reg <= pwr_next;
    end
  end

  // exit needs no clock edge: clk_en rising clears the flop directly
  always_ff @(posedge MCLK_I or negedge rst_n or posedge lnk.clk_en) begin
    if (!rst_n) begin
      sref_reg <= 1'b0;
    end else if (lnk.clk_en) begin
      sref_reg <= 1'b0;
    end else if (self_refresh_entry) begin
      sref_reg <= 1'b1;
    end
  end

  always_comb begin
    open_next = open_reg;
    if (burst_cnt_reg == 3'h1 && auto_close_reg) begin
      open_next[burst_bank_reg] = 1'b0;
    end
    if (exec && cmd == CMD_ROW_OPEN) begin
      open_next[lnk.array_sel] = 1'b1;
    end
    if (exec && cmd == CMD_BANK_CLOSE) begin
      if (lnk.addr[ADDR_TEN_BIT]) begin
        open_next = '0;
      end else begin
        open_next[lnk.array_sel] = 1'b0;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      open_reg <= '0;
    end else begin
      open_reg <= open_next;
    end
  end

  // burst counter keeps running through power-down entry
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      burst_cnt_reg  <= 3'h0;
      burst_bank_reg <= '0;
      auto_close_reg <= 1'b0;
      chop_reg       <= 1'b0;
    end else if (exec && (cmd == CMD_READ || cmd == CMD_STORE)) begin
      burst_cnt_reg  <= chop ? BURST_CYC_FOUR : BURST_CYC_EIGHT;
      burst_bank_reg <= lnk.array_sel;
      auto_close_reg <= lnk.addr[ADDR_TEN_BIT];
      chop_reg       <= chop;
    end else if (burst_cnt_reg != 3'h0) begin
      burst_cnt_reg  <= burst_cnt_reg - 3'h1;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      MODE_REGS_O <= '0;
    end else if (exec && cmd == CMD_MODE_WRITE) begin
      MODE_REGS_O[lnk.array_sel[DCD_MR_SEL_W-1:0]] <= lnk.addr;
    end
  end

  // only the very first long calibration gets the init window
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      zq_seen_reg <= 1'b0;
      ZQ_LONG_O   <= 1'b0;
      ZQ_INIT_O   <= 1'b0;
    end else if (exec && cmd == CMD_IMP_CAL) begin
      ZQ_LONG_O   <= lnk.addr[ADDR_TEN_BIT];
      ZQ_INIT_O   <= lnk.addr[ADDR_TEN_BIT] && !zq_seen_reg;
      if (lnk.addr[ADDR_TEN_BIT]) begin
        zq_seen_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      CMD_O     <= CMD_CHIP_IDLE;
      CMD_STB_O <= 1'b0;
      BANK_O    <= '0;
      ADDR_O    <= '0;
    end else begin
      CMD_STB_O <= exec || self_refresh_entry;
      if (exec || self_refresh_entry) begin
        CMD_O  <= cmd;
        BANK_O <= lnk.array_sel;
        ADDR_O <= lnk.addr;
      end
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      VIOLATION_O  <= 1'b0;
      PWR_STATE_O  <= PWR_ON;
      OPEN_BANKS_O <= '0;
      BURST_ACT_O  <= 1'b0;
      CHOP_O       <= 1'b0;
      AUTO_CLOSE_O <= 1'b0;
    end else begin
      VIOLATION_O  <= viol;
      PWR_STATE_O  <= pwr_next;
      OPEN_BANKS_O <= open_next;
      BURST_ACT_O  <= burst_cnt_reg > 3'h1 || (exec && cmd inside {CMD_READ,
                      CMD_STORE});
      // new burst shows its own chop and close flags from its first cycle
      CHOP_O       <= burst_go ? chop : chop_reg;
      AUTO_CLOSE_O <= burst_go ? lnk.addr[ADDR_TEN_BIT] : auto_close_reg;
    end
  end

  // no refresh engine runs while powered down; refresh only from a command
  assign SELF_REF_O = sref_reg;

endmodule : dcd_device

/* File: rtl/dcd_ctrl.sv */
`timescale 1ns/1ps
module dcd_ctrl
  import dcd_pkg::*;
(
  input  wire logic        MCLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [1:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  dcd_link_if.ctl          lnk
);

  logic        req;
  logic        done;
  logic        cmd_wr;
  logic        new_cke;
  logic        legal;
  logic        can_go;
  logic        is_burst;
  dcd_cmd_t    code;
  logic [3:0]  hold_cnt_reg;
  logic [2:0]  burst_cnt_reg;
  logic        err_reg;
  logic [1:0]  ctrl_reg;
  logic [31:0] cmd_word_reg;

  always_comb begin
    req      = AVS_READ_I || AVS_WRITE_I;
    done     = req && !AVS_WAITREQUEST_O;
    cmd_wr   = AVS_WRITE_I && (AVS_ADDRESS_I == REG_CMD);
    code     = dcd_cmd_t'(AVS_WRITEDATA_I[CMD_CODE_LSB +: 4]);
    new_cke  = AVS_WRITEDATA_I[CMD_CKE_BIT];
    is_burst = (code == CMD_READ) || (code == CMD_STORE);
    // clk_en may change only with an idle command, or refresh going low
    if (new_cke != lnk.clk_en) begin
      legal = dcd_is_idle(code) || (code == CMD_ROW_RENEW && !new_cke);
    end else begin
      // while clk_en stays low nothing but idle commands, no refresh
      legal = lnk.clk_en || dcd_is_idle(code);
    end
    legal  = legal && (code inside {CMD_MODE_WRITE, CMD_ROW_RENEW,
              CMD_BANK_CLOSE, CMD_ROW_OPEN, CMD_STORE, CMD_READ, CMD_IMP_CAL,
              CMD_IDLE_CYCLE, CMD_CHIP_IDLE});
    can_go = !cmd_wr
          || ((hold_cnt_reg == 4'h0 || new_cke == lnk.clk_en)
              && (burst_cnt_reg == 3'h0 || !is_burst));
  end

  // one wait cycle minimum; a command write stalls if it changes clk_en during the hold, or is a burst while one is pending
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
    end else begin
      AVS_WAITREQUEST_O <= !(req && can_go && AVS_WAITREQUEST_O);
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (AVS_READ_I && AVS_WAITREQUEST_O) begin
      case (AVS_ADDRESS_I)
        REG_CMD:    AVS_READDATA_O <= cmd_word_reg;
        REG_ADDR:   AVS_READDATA_O <= 32'({lnk.array_sel, lnk.addr});
        REG_STATUS: begin
          AVS_READDATA_O                <= 32'h0000_0000;
          AVS_READDATA_O[STAT_BUSY_BIT] <= (hold_cnt_reg != 4'h0)
                                        || (burst_cnt_reg != 3'h0);
          AVS_READDATA_O[STAT_ERR_BIT]  <= err_reg;
          AVS_READDATA_O[STAT_CKE_BIT]  <= lnk.clk_en;
        end
        REG_CTRL:   AVS_READDATA_O <= 32'(ctrl_reg);
        default:    AVS_READDATA_O <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      ctrl_reg     <= CTRL_RESET_VAL;
      lnk.array_sel <= '0;
      lnk.addr     <= '0;
    end else if (done && AVS_WRITE_I && AVS_ADDRESS_I == REG_CTRL) begin
      ctrl_reg     <= AVS_WRITEDATA_I[1:0];
    end else if (done && AVS_WRITE_I && AVS_ADDRESS_I == REG_ADDR) begin
      lnk.addr      <= AVS_WRITEDATA_I[ADDR_LSB +: DCD_ADDR_W];
      lnk.array_sel <= AVS_WRITEDATA_I[BANK_LSB +: DCD_BANK_W];
    end
  end

  // device reset is held low until software releases it
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lnk.async_rst_n <= 1'b0;
      lnk.term_en     <= 1'b0;
    end else begin
      lnk.async_rst_n <= ctrl_reg[CTRL_RST_BIT];
      lnk.term_en     <= ctrl_reg[CTRL_TERM_BIT];
    end
  end

  // set wins over the software clear
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      err_reg <= 1'b0;
    end else if (done && cmd_wr && !legal) begin
      err_reg <= 1'b1;
    end else if (done && AVS_WRITE_I && AVS_ADDRESS_I == REG_STATUS) begin
      err_reg <= 1'b0;
    end
  end

  // strobes default to chip_idle_cmd; a command lasts exactly one cycle
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      {lnk.chip_sel_n, lnk.row_strobe_n, lnk.col_strobe_n,
       lnk.write_strobe_n} <= CMD_CHIP_IDLE;
      lnk.clk_en   <= 1'b0;
      cmd_word_reg <= CMD_RESET_VAL;
    end else if (done && cmd_wr && legal) begin
      {lnk.chip_sel_n, lnk.row_strobe_n, lnk.col_strobe_n,
       lnk.write_strobe_n} <= code;
      lnk.clk_en   <= new_cke;
      cmd_word_reg <= AVS_WRITEDATA_I;
    end else begin
      {lnk.chip_sel_n, lnk.row_strobe_n, lnk.col_strobe_n,
       lnk.write_strobe_n} <= CMD_CHIP_IDLE;
    end
  end

  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      hold_cnt_reg <= 4'h0;
    end else if (done && cmd_wr && legal && new_cke != lnk.clk_en) begin
      hold_cnt_reg <= CKE_HOLD_CYC;
    end else if (hold_cnt_reg != 4'h0) begin
      hold_cnt_reg <= hold_cnt_reg - 4'h1;
    end
  end

  // conservative: always assumes a full eight-beat burst
  always_ff @(posedge MCLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      burst_cnt_reg <= 3'h0;
    end else if (done && cmd_wr && legal && is_burst) begin
      burst_cnt_reg <= BURST_CYC_EIGHT + 3'h1;
    end else if (burst_cnt_reg != 3'h0) begin
      burst_cnt_reg <= burst_cnt_reg - 3'h1;
    end
  end

endmodule : dcd_ctrl

/* File: tb/dcd_link_properties.sv */
`timescale 1ns/1ps
module dcd_link_properties
  import dcd_pkg::*;
(
  input wire logic                       MCLK_I,
  input wire logic                       RST_N_I,
  input wire logic                       async_rst_n,
  input wire logic                       clk_en,
  input wire logic                       chip_sel_n,
  input wire logic                       row_strobe_n,
  input wire logic                       col_strobe_n,
  input wire logic                       write_strobe_n,
  input wire logic                       CMD_STB_O,
  input wire logic [1:0]                 PWR_STATE_O,
  input wire logic                       SELF_REF_O,
  input wire logic [(1<<DCD_BANK_W)-1:0] OPEN_BANKS_O,
  input wire logic                       BURST_ACT_O,
  input wire logic                       CHOP_O
);
  logic idle_c;
  logic renew_c;
  // chip idle and idle cycle are one class for the device
  assign idle_c  = chip_sel_n | (row_strobe_n & col_strobe_n & write_strobe_n);
  assign renew_c = {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n}
                   == CMD_ROW_RENEW;

  default clocking dcb @(posedge MCLK_I);
  endclocking
  default disable iff (!RST_N_I);

  a_cmd_one_cycle: assert property (
    !chip_sel_n |=> chip_sel_n) else $error("command held too long");
  a_cke_hold_min: assert property (
    $changed(clk_en) |=> $stable(clk_en) [*3])
    else $error("clk_en changed too soon");
  a_idle_quiet: assert property (
    idle_c && clk_en && $past(clk_en) |=> !CMD_STB_O)
    else $error("idle command executed something");
  a_pd_entry: assert property (
    $fell(clk_en) && idle_c && async_rst_n |=>
      PWR_STATE_O == (($past(OPEN_BANKS_O) != 0) ? PWR_PD_ACT : PWR_PD_PRE))
    else $error("wrong power-down entry");
  a_pd_keep: assert property (
    !clk_en && !$past(clk_en) && async_rst_n && PWR_STATE_O != PWR_ON
      |=> $stable(PWR_STATE_O)) else $error("power-down not held");
  a_pd_exit: assert property (
    $rose(clk_en) && idle_c && async_rst_n && PWR_STATE_O != PWR_ON
      |=> PWR_STATE_O == PWR_ON) else $error("power-down not left");
  a_sref_entry: assert property (
    $fell(clk_en) && renew_c && OPEN_BANKS_O == 0 && !BURST_ACT_O
      && async_rst_n |=> SELF_REF_O && CMD_STB_O)
    else $error("self refresh not entered");
  a_sref_exit: assert property (
    clk_en |-> !SELF_REF_O) else $error("self refresh kept with clk_en");
  a_dev_reset: assert property (
    !async_rst_n |-> OPEN_BANKS_O == 0 && !SELF_REF_O && PWR_STATE_O == PWR_ON)
    else $error("device state during reset");
  a_burst_eight: assert property (
    $rose(BURST_ACT_O) && !CHOP_O |-> BURST_ACT_O [*4] ##1 !BURST_ACT_O)
    else $error("eight-beat burst length");
  a_burst_chop: assert property (
    $rose(BURST_ACT_O) && CHOP_O |-> BURST_ACT_O [*2] ##1 !BURST_ACT_O)
    else $error("chopped burst length");

  c_pd_entry: cover property ($fell(clk_en) && idle_c);
  c_sref:     cover property ($rose(SELF_REF_O));
  c_chop:     cover property ($rose(BURST_ACT_O) && CHOP_O);
endmodule : dcd_link_properties

/* File: tb/tb_ddr3_command_decoder.sv */
`timescale 1ns/1ps
module tb_ddr3_command_decoder;
  import dcd_pkg::*;
  logic        mclk;
  logic        rst_n;
  logic [1:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_wdata;
  logic [31:0] avs_rdata;
  logic        avs_wait;
  logic [3:0]  cmd_code;
  logic        cmd_stb;
  logic [2:0]  bank_q;
  logic [15:0] addr_q;
  logic [1:0]  pwr;
  logic        sref;
  logic [7:0]  open_banks;
  logic        burst;
  logic        chop;
  logic        auto_cl;
  logic        zq_long;
  logic        zq_init;
  logic        viol;
  logic [DCD_MR_NUM-1:0][DCD_ADDR_W-1:0] mode_regs;
  int          n_fail;
  int          total_checks;
  int          m_open;
  int          m_pwr;
  int          m_sref;
  int          m_cke;
  int          m_zqf;
  int          m_mr[4];
  int          i;
  logic [2:0]  b;
  logic [15:0] a;
  logic [31:0] d;

  dcd_link_if lnk ();
  dcd_ctrl dcd_ctrl_inst (
    .MCLK_I(mclk), .RST_N_I(rst_n), .AVS_ADDRESS_I(avs_address),
    .AVS_READ_I(avs_read), .AVS_WRITE_I(avs_write),
    .AVS_WRITEDATA_I(avs_wdata), .AVS_READDATA_O(avs_rdata),
    .AVS_WAITREQUEST_O(avs_wait), .lnk(lnk));
  dcd_device dcd_device_inst (
    .MCLK_I(mclk), .RST_N_I(rst_n), .lnk(lnk), .CMD_O(cmd_code),
    .CMD_STB_O(cmd_stb), .BANK_O(bank_q), .ADDR_O(addr_q),
    .PWR_STATE_O(pwr), .SELF_REF_O(sref), .OPEN_BANKS_O(open_banks),
    .BURST_ACT_O(burst), .CHOP_O(chop), .AUTO_CLOSE_O(auto_cl),
    .ZQ_LONG_O(zq_long), .ZQ_INIT_O(zq_init), .MODE_REGS_O(mode_regs),
    .VIOLATION_O(viol));
  dcd_link_properties props (
    .MCLK_I(mclk), .RST_N_I(rst_n), .async_rst_n(lnk.async_rst_n),
    .clk_en(lnk.clk_en), .chip_sel_n(lnk.chip_sel_n),
    .row_strobe_n(lnk.row_strobe_n), .col_strobe_n(lnk.col_strobe_n),
    .write_strobe_n(lnk.write_strobe_n), .CMD_STB_O(cmd_stb),
    .PWR_STATE_O(pwr), .SELF_REF_O(sref), .OPEN_BANKS_O(open_banks),
    .BURST_ACT_O(burst), .CHOP_O(chop));

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  task automatic tally_and_finish();
    if (n_fail == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // one avalon transfer; request held until waitrequest is seen low
  task automatic av(input logic wr, input logic [1:0] ad,
                    input logic [31:0] wd, output logic [31:0] rd);
    int k;
    @(posedge mclk);
    avs_address <= ad;
    avs_wdata   <= wd;
    avs_write   <= wr;
    avs_read    <= !wr;
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (avs_wait !== 1'b0 && k < 1000);
    rd = avs_rdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (avs_wait !== 1'b0) begin
      n_fail++;
      tally_and_finish();
    end
  endtask : av

  function automatic logic [15:0] ra(input logic a10, input logic a12);
    logic [15:0] r;
    r = 16'($urandom);
    r[ADDR_TEN_BIT] = a10;
    r[ADDR_TWELVE_BIT] = a12;
    return r;
  endfunction : ra

  // model predicts the device, then both are compared
  task automatic cmd(input logic [3:0] code, input logic cke,
                     input logic [2:0] bk, input logic [15:0] ad);
    logic [31:0] rd;
    logic stb;
    logic vio;
    logic ch;
    logic zi;
    int   bl;
    stb = 1'b0;
    vio = 1'b0;
    zi  = 1'b0;
    bl  = m_mr[0] & 3;
    ch  = (bl == 2) || (bl == 1 && !ad[ADDR_TWELVE_BIT]);
    if (m_cke != 0 && !cke) begin
      if (code == CMD_IDLE_CYCLE) m_pwr = (m_open != 0) ? 2 : 1;
      else begin
        m_sref = 1;
        stb = 1'b1;
      end
    end else if (m_cke == 0 && cke) begin
      m_pwr  = 0;
      m_sref = 0;
    end else if (cke) begin
      case (code)
        CMD_MODE_WRITE, CMD_ROW_RENEW: begin
          vio = (m_open != 0);
          if (!vio && code == CMD_MODE_WRITE) m_mr[bk[1:0]] = ad;
        end
        CMD_BANK_CLOSE: m_open = ad[10] ? 0 : m_open & ~(1 << bk);
        CMD_ROW_OPEN: begin
          vio = m_open[bk];
          m_open |= 1 << bk;
        end
        CMD_READ, CMD_STORE: begin
          vio = !m_open[bk];
          if (ad[10]) m_open &= ~(1 << bk);
        end
        CMD_IMP_CAL: begin
          zi = ad[ADDR_TEN_BIT] && (m_zqf != 0);
          if (ad[10]) m_zqf = 0;
        end
        default: ;
      endcase
      stb = !vio && code != CMD_IDLE_CYCLE;
    end
    av(1'b1, REG_ADDR, {13'h0, bk, ad}, rd);
    av(1'b1, REG_CMD, {27'h0, cke, code}, rd);
    @(posedge mclk);
    #1;
    chk(cmd_stb, stb);
    chk(viol, vio);
    if (stb) chk(cmd_code, code);
    if (stb) chk(bank_q, bk);
    if (stb) chk(addr_q, ad);
    repeat (6) @(posedge mclk);
    #1;
    chk(open_banks, m_open);
    chk(pwr, m_pwr);
    chk(sref, m_sref);
    for (int j = 0; j < 4; j++) chk(mode_regs[j], m_mr[j]);
    if (stb && (code == CMD_READ || code == CMD_STORE)) begin
      chk(chop, ch);
      chk(auto_cl, ad[10]);
    end
    if (stb && code == CMD_IMP_CAL) chk({zq_long, zq_init}, {ad[10], zi});
    m_cke = cke;
  endtask : cmd

  initial begin
    rst_n = 1'b0;
    avs_address = 2'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_wdata = 32'h0;
    n_fail = 0;
    total_checks = 0;
    {m_open, m_pwr, m_sref, m_cke} = '0;
    m_zqf = 1;
    m_mr = '{default: 0};
    void'($urandom(32'h004a6ff8));
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    av(1'b1, REG_CTRL, 32'h1, d);
    cmd(CMD_IDLE_CYCLE, 1'b1, 3'h0, 16'h0);
    for (i = 3; i >= 1; i--) cmd(CMD_MODE_WRITE, 1'b1, 3'(i), ra(0, 1));
    for (i = 0; i < 3; i++) begin
      b = 3'($urandom_range(7, 0));
      a = ra(0, 0);
      a[MR0_BL_LSB +: 2] = 2'(i);
      cmd(CMD_MODE_WRITE, 1'b1, 3'h4, a);
      cmd(CMD_ROW_OPEN, 1'b1, b, ra(0, 1));
      cmd(CMD_READ, 1'b1, b, ra(0, 0));
      cmd(CMD_STORE, 1'b1, b, ra(1, 1));
      cmd(CMD_READ, 1'b1, b, ra(0, 1));
    end
    av(1'b1, REG_CTRL, 32'h3, d);
    cmd(CMD_ROW_OPEN, 1'b1, 3'h1, ra(0, 0));
    cmd(CMD_ROW_OPEN, 1'b1, 3'h6, ra(1, 0));
    cmd(CMD_ROW_OPEN, 1'b1, 3'h6, ra(0, 0));
    cmd(CMD_BANK_CLOSE, 1'b1, 3'h6, ra(0, 1));
    cmd(CMD_ROW_RENEW, 1'b1, 3'h0, ra(0, 0));
    cmd(CMD_IDLE_CYCLE, 1'b0, 3'h0, 16'h0);
    cmd(CMD_READ, 1'b0, 3'h1, ra(0, 0));
    av(1'b0, REG_STATUS, 32'h0, d);
    chk(d[STAT_ERR_BIT], 1'b1);
    av(1'b1, REG_STATUS, 32'h0, d);
    av(1'b0, REG_STATUS, 32'h0, d);
    chk(d[STAT_ERR_BIT], 1'b0);
    cmd(CMD_IDLE_CYCLE, 1'b1, 3'h0, 16'h0);
    cmd(CMD_BANK_CLOSE, 1'b1, 3'h5, ra(1, 0));
    cmd(CMD_IDLE_CYCLE, 1'b0, 3'h0, 16'h0);
    cmd(CMD_IDLE_CYCLE, 1'b1, 3'h0, 16'h0);
    cmd(CMD_ROW_RENEW, 1'b1, 3'h0, ra(0, 0));
    cmd(CMD_ROW_RENEW, 1'b0, 3'h0, ra(0, 0));
    cmd(CMD_IDLE_CYCLE, 1'b1, 3'h0, 16'h0);
    cmd(CMD_IMP_CAL, 1'b1, 3'h0, ra(1, 0));
    cmd(CMD_IMP_CAL, 1'b1, 3'h0, ra(1, 1));
    cmd(CMD_IMP_CAL, 1'b1, 3'h0, ra(0, 0));
    cmd(CMD_ROW_OPEN, 1'b1, 3'h3, ra(0, 0));
    // dropping the device reset clears its state but not the controller's
    av(1'b1, REG_CTRL, 32'h0, d);
    repeat (3) @(posedge mclk);
    #1;
    chk({open_banks, pwr, cmd_code}, {8'h0, 2'h0, 4'hf});
    m_open = 0;
    m_zqf = 1;
    m_mr = '{default: 0};
    av(1'b1, REG_CTRL, 32'h1, d);
    cmd(CMD_IMP_CAL, 1'b1, 3'h0, ra(1, 0));
    tally_and_finish();
  end
endmodule : tb_ddr3_command_decoder
